// ==== core/cpic_clock_idle_ctrl.sv ====
// clock divider control register, idle request and core clock gating
`timescale 1ns/10ps
module cpic_clock_idle_ctrl
  import cpic_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic sfrWrEn,
  input wire logic [7:0] sfrAddr,
  input wire logic [7:0] sfrWrData,
  output logic [7:0] clkDivRdData,
  input wire logic anyIrq,
  input wire logic enabledIrq,
  input wire logic supervisorRst,
  input wire logic watchdogRst,
  input wire logic powerDownReq,
  output logic coreClkEn,
  output logic periphClkEn,
  output logic idleActive,
  output logic idleRequest,
  output logic debugCompareEnable,
  output logic portHold,
  output logic coreRestartHold
);
  cpic_div_if divBus();
  cpic_divider u_div (
    .core_clk(core_clk),
    .reset(reset),
    .dv(divBus)
  );

  logic [7:0] clkDiv_r;
  logic [7:0] clkDiv_nxt;
  logic idle_r;
  logic idle_nxt;
  cpic_state_t state_r;
  cpic_state_t state_nxt;
  logic [CPIC_RST_W-1:0] rstCnt_r;
  logic [CPIC_RST_W-1:0] rstCnt_nxt;
  logic clkDivWr;
  logic idleWr;
  logic irqRestore;
  logic wakeIrq;

  assign clkDivWr = sfrWrEn && (sfrAddr == CPIC_CLKDIV_ADDR);
  assign idleWr = sfrWrEn && (sfrAddr == CPIC_POWER_CONTROL_REG_ADDR) && sfrWrData[CPIC_IDLE_BIT]; // R08
  assign irqRestore = anyIrq && clkDiv_r[CPIC_AUTO_BIT]; // R02
  // interrupt restore beats a simultaneous write of the divider field
  always_comb
  begin
    clkDiv_nxt = clkDiv_r;
    if (clkDivWr)
      clkDiv_nxt = sfrWrData & CPIC_CLKDIV_MASK;
    if (irqRestore)
      clkDiv_nxt[CPIC_SEL_MSB:CPIC_SEL_LSB] = CPIC_SEL_FULL; // R02
  end
  assign wakeIrq = enabledIrq && idle_r; // R11
  // watchdog deliberately absent from the idle wake path
  always_comb
  begin
    state_nxt = state_r;
    idle_nxt = idle_r;
    rstCnt_nxt = rstCnt_r;
    unique case (state_r)
      CPIC_RUN:
        if (idleWr && !enabledIrq)
        begin
          state_nxt = CPIC_IDLE;
          idle_nxt = 1'b1; // R08
        end
      CPIC_IDLE:
        if (wakeIrq)
        begin
          state_nxt = CPIC_RUN;
          idle_nxt = 1'b0; // R11
        end
      CPIC_RESTART:
        if (rstCnt_r == '0)
          state_nxt = CPIC_RUN;
        else
          rstCnt_nxt = CPIC_RST_W'(rstCnt_r - 1'b1);
    endcase
    if (supervisorRst)
    begin
      state_nxt = CPIC_RESTART; // R07
      idle_nxt = 1'b0; // R12
      rstCnt_nxt = CPIC_RESTART_CNT - 1'b1; // R12
    end
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      clkDiv_r <= CPIC_CLKDIV_RESET; // R01 R03
      idle_r <= 1'b0;
      state_r <= CPIC_RUN;
      rstCnt_r <= '0;
    end
    else
    begin
      clkDiv_r <= clkDiv_nxt;
      idle_r <= idle_nxt;
      state_r <= state_nxt;
      rstCnt_r <= rstCnt_nxt;
    end
  end

  assign divBus.sel = clkDiv_r[CPIC_SEL_MSB:CPIC_SEL_LSB]; // R01 R14
  assign clkDivRdData = clkDiv_r & CPIC_CLKDIV_MASK;
  // only the core enable drops in idle; core state holds since its clock stops
  assign coreClkEn = divBus.tick && (state_r == CPIC_RUN) && !powerDownReq; // R05 R09 R04
  assign periphClkEn = !powerDownReq; // R06
  assign idleActive = (state_r == CPIC_IDLE); // R04
  assign idleRequest = idle_r;
  assign debugCompareEnable = clkDiv_r[CPIC_DBG_BIT]; // R03
  assign portHold = (state_r == CPIC_IDLE); // R10
  assign coreRestartHold = (state_r == CPIC_RESTART); // R12

  sequence s_irq_in_idle;
    idleActive && enabledIrq && !supervisorRst;
  endsequence
  sequence s_back_running;
    !idleActive && !idleRequest;
  endsequence

  a_auto_restore: assert property (@(posedge core_clk) disable iff (reset)
    irqRestore |=> divBus.sel == CPIC_SEL_FULL) else $error("auto restore missed"); // R02
  a_no_restore: assert property (@(posedge core_clk) disable iff (reset)
    (!clkDiv_r[CPIC_AUTO_BIT] && !clkDivWr) |=> $stable(divBus.sel))
    else $error("divider changed without write"); // R02
  a_idle_gates: assert property (@(posedge core_clk) disable iff (reset)
    idleActive |-> !coreClkEn) else $error("core clock ran in idle"); // R05
  a_periph_runs: assert property (@(posedge core_clk) disable iff (reset)
    (idleActive && !powerDownReq) |-> periphClkEn) else $error("peripheral clock stopped"); // R06
  a_idle_enter: assert property (@(posedge core_clk) disable iff (reset)
    (idleWr && !idleActive && !enabledIrq && !supervisorRst && state_r == CPIC_RUN)
    |=> idleActive && idleRequest) else $error("idle not entered"); // R08
  a_irq_wake: assert property (@(posedge core_clk) disable iff (reset)
    s_irq_in_idle |=> s_back_running) else $error("interrupt did not wake"); // R11
  a_wdog_ignored: assert property (@(posedge core_clk) disable iff (reset)
    (idleActive && watchdogRst && !enabledIrq && !supervisorRst) |=> idleActive)
    else $error("watchdog ended idle"); // R07
  a_restart_len: assert property (@(posedge core_clk) disable iff (reset)
    $rose(coreRestartHold) && !supervisorRst |-> coreRestartHold [*8])
    else $error("restart too short"); // R12
  a_sup_clear: assert property (@(posedge core_clk) disable iff (reset)
    supervisorRst |=> !idleRequest && coreRestartHold) else $error("supervisor reset ignored"); // R12
  a_port_hold: assert property (@(posedge core_clk) disable iff (reset)
    idleActive |-> portHold) else $error("ports not held"); // R10
  a_dbg_bit: assert property (@(posedge core_clk) disable iff (reset)
    clkDivWr |=> debugCompareEnable == $past(sfrWrData[CPIC_DBG_BIT]))
    else $error("debug enable not written"); // R03
endmodule

// ==== core/cpic_div_if.sv ====
// carrier between the control logic and the divider
`timescale 1ns/10ps
interface cpic_div_if;
  logic [2:0] sel;
  logic tick;
  modport ctrl (output sel, input tick);
  modport div (input sel, output tick);
endinterface

// ==== core/cpic_divider.sv ====
// oscillator divider producing core clock enable ticks
`timescale 1ns/10ps
module cpic_divider
  import cpic_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  cpic_div_if.div dv
);
  logic [CPIC_DIV_W-1:0] cnt_r;
  logic [CPIC_DIV_W-1:0] cnt_nxt;
  logic [2:0] activeSel_r;
  logic [CPIC_DIV_W-1:0] limit;
  logic wrap;

  // period minus one: 2^sel for small codes, 1024 / 2048 for the top two
  assign limit = (activeSel_r == CPIC_SEL_1024) ? CPIC_DIV_W'((1 << CPIC_SHIFT_1024) - 1) :
                 (activeSel_r == CPIC_SEL_2048) ? CPIC_DIV_W'((1 << CPIC_SHIFT_2048) - 1) :
                 CPIC_DIV_W'((1 << activeSel_r) - 1); // R01
  assign wrap = (cnt_r == limit);
  assign cnt_nxt = wrap ? '0 : CPIC_DIV_W'(cnt_r + 1'b1);
  assign dv.tick = wrap;

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      cnt_r <= '0;
      activeSel_r <= CPIC_SEL_FULL;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      // new ratio only at a period end, so no runt core clock
      if (wrap)
        activeSel_r <= dv.sel; // R14
    end
  end

  a_sel_boundary: assert property (@(posedge core_clk) disable iff (reset)
    !$past(wrap) |-> $stable(activeSel_r)) else $error("divider ratio changed mid period"); // R14
  a_full_speed: assert property (@(posedge core_clk) disable iff (reset)
    (activeSel_r == CPIC_SEL_FULL) |-> wrap) else $error("full speed not every cycle"); // R01
endmodule

// ==== core/cpic_pkg.sv ====
// constants and types for the core clock prescale and idle control block
// Notes on behaviour
// R01: divider codes 0-5 give /1../32, 6 gives /1024, 7 gives /2048; reset code 0.
// R02: with auto restore set, any interrupt forces divider code to zero.
// R03: debug compare enable at bit 4 gates breakpoint comparators; resets enabled.
// R04: three software reduced-power modes: idle, power-down, reduced frequency.
// R05: idle stops only the core clock; peripheral clock keeps running.
// R06: peripherals, timers and external interrupts stay clocked during idle.
// R07: low-voltage, debug and external resets act in idle; watchdog does not.
// R08: setting idle request stops execution after the setting instruction.
// R09: core state and memories are held because the core clock stops.
// R10: port 1, 3 and 4 output levels are frozen during idle.
// R11: enabled interrupt clears idle request and wakes the core.
// R12: supervisor reset clears idle request; core restarts after three machine cycles.
// R13: software should disable unused peripherals before idle.
// R14: a new divider selection is applied only at a divided clock boundary.
package cpic_pkg;
  localparam logic [7:0] CPIC_CLKDIV_ADDR = 8'h_00F9;
  localparam logic [7:0] CPIC_CLKDIV_RESET = 8'h_0010;
  localparam logic [7:0] CPIC_CLKDIV_MASK = 8'h_001F;
  localparam logic [7:0] CPIC_POWER_CONTROL_REG_ADDR = 8'h_0087;
  localparam int CPIC_SEL_LSB = 0;
  localparam int CPIC_SEL_MSB = 2;
  localparam int CPIC_AUTO_BIT = 3;
  localparam int CPIC_DBG_BIT = 4;
  localparam int CPIC_IDLE_BIT = 0;
  localparam logic [2:0] CPIC_SEL_FULL = 3'h_0;
  localparam logic [2:0] CPIC_SEL_1024 = 3'h_6;
  localparam logic [2:0] CPIC_SEL_2048 = 3'h_7;
  localparam int CPIC_DIV_W = 11;
  localparam int CPIC_SHIFT_1024 = 10;
  localparam int CPIC_SHIFT_2048 = 11;
  // machine cycle length in core clocks and the restart delay after supervisor reset
  localparam int CPIC_CLK_PER_MC = 4;
  localparam int CPIC_RESTART_MC = 3;
  localparam int CPIC_RESTART_CLKS = CPIC_CLK_PER_MC * CPIC_RESTART_MC;
  localparam int CPIC_RST_W = 4;
  localparam logic [3:0] CPIC_RESTART_CNT = 4'(CPIC_RESTART_CLKS);
  typedef enum logic [1:0] {CPIC_RUN, CPIC_IDLE, CPIC_RESTART} cpic_state_t;
endpackage

// ==== test/cpic_core_model.sv ====
// behavioural core model counting executed core cycles
`timescale 1ns/10ps
module cpic_core_model
  import cpic_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic coreClkEn,
  input wire logic coreRestartHold,
  output logic [15:0] instrCount
);
  // counts only enabled core cycles, so a frozen count shows held state
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      instrCount <= 16'h_0000;
    else if (coreClkEn && !coreRestartHold)
      instrCount <= instrCount + 16'h_0001;
  end
endmodule

// ==== test/tb.sv ====
// self-checking bench for the clock prescale and idle control block
`timescale 1ns/10ps
module tb
  import cpic_pkg::*;
;
  logic core_clk = 0, reset = 1, sfrWrEn = 0, anyIrq = 0, enabledIrq = 0;
  logic supervisorRst = 0, watchdogRst = 0, powerDownReq = 0;
  logic [7:0] sfrAddr = 8'h_0000, sfrWrData = 8'h_0000;
  wire logic [7:0] rd;
  wire logic cEn, pEn, idA, idR, dbg, pH, rH;
  wire logic [15:0] instrCount;
  int numErrors = 0, testsRun = 0, n, m;
  always #2.5 core_clk = ~core_clk;
  cpic_clock_idle_ctrl i_cpic_clock_idle_ctrl (.core_clk(core_clk), .reset(reset),
    .sfrWrEn(sfrWrEn), .sfrAddr(sfrAddr), .sfrWrData(sfrWrData), .clkDivRdData(rd),
    .anyIrq(anyIrq), .enabledIrq(enabledIrq), .supervisorRst(supervisorRst),
    .watchdogRst(watchdogRst), .powerDownReq(powerDownReq), .coreClkEn(cEn),
    .periphClkEn(pEn), .idleActive(idA), .idleRequest(idR), .debugCompareEnable(dbg),
    .portHold(pH), .coreRestartHold(rH));
  cpic_core_model i_cpic_core_model (.core_clk(core_clk), .reset(reset), .coreClkEn(cEn),
    .coreRestartHold(rH), .instrCount(instrCount));
  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    testsRun++;
    if (got !== exp)
    begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      numErrors++;
    end
  endtask
  task tick(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    sfrWrEn <= 1'b1;
    sfrAddr <= a;
    sfrWrData <= d;
    @(posedge core_clk);
    sfrWrEn <= 1'b0;
    #1;
  endtask
  // cycles from one core enable pulse to the next
  task period(output int p);
    p = 0;
    while (cEn !== 1'b1 && p < 5000)
    begin
      tick(1);
      p++;
    end
    p = 0;
    do
    begin
      tick(1);
      p++;
    end while (cEn !== 1'b1 && p < 5000);
  endtask
  task printVerdict();
    if (numErrors == 0 && testsRun > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge core_clk);
    reset <= 1'b0;
    tick(1);
    chk("divider reset", 16'h_0010, 16'(rd));
    chk("debug reset", 16'h_0001, 16'(dbg));
    for (int k = 0; k < 8; k++)
    begin
      wr(CPIC_CLKDIV_ADDR, 8'(k));
      period(n);
      period(n);
      m = (k < 6) ? (1 << k) : ((k == 6) ? 1024 : 2048);
      chk("core period", 16'(m), 16'(n));
    end
    chk("debug off", 16'h_0000, 16'(dbg));
    for (int a = 0; a < 2; a++)
    begin
      wr(CPIC_CLKDIV_ADDR, a ? 8'h_0005 : 8'h_000D);
      @(posedge core_clk);
      anyIrq <= 1'b1;
      tick(1);
      anyIrq <= 1'b0;
      tick(1);
      chk("restore", a ? 16'h_0005 : 16'h_0008, 16'(rd));
    end
    wr(8'h_00F8, 8'h_0013);
    chk("unmapped", 16'h_0005, 16'(rd));
    wr(CPIC_POWER_CONTROL_REG_ADDR, 8'h_0001);
    n = instrCount;
    tick(20);
    chk("idle flags", 16'h_001D, 16'({idA, idR, pH, cEn, pEn}));
    chk("core held", 16'(n), instrCount);
    watchdogRst <= 1'b1;
    tick(1);
    watchdogRst <= 1'b0;
    tick(1);
    chk("wdog idle", 16'h_0001, 16'(idA));
    enabledIrq <= 1'b1;
    tick(1);
    enabledIrq <= 1'b0;
    tick(1);
    chk("irq wake", 16'h_0000, 16'({idA, idR}));
    wr(CPIC_POWER_CONTROL_REG_ADDR, 8'h_0001);
    supervisorRst <= 1'b1;
    tick(1);
    supervisorRst <= 1'b0;
    n = 0;
    while (rH === 1'b1 && n < 50)
    begin
      tick(1);
      n++;
    end
    chk("restart hold", 16'(CPIC_RESTART_CLKS), 16'(n));
    chk("sup clear", 16'h_0000, 16'(idR));
    powerDownReq <= 1'b1;
    tick(1);
    chk("power down", 16'h_0000, 16'({cEn, pEn}));
    printVerdict();
  end
  initial
  begin
    #200us;
    numErrors++;
    printVerdict();
  end
endmodule
